//--- hw/toc_pkg.sv
// Constants, field positions and mode encoding for timer one
// Assumes an 8-bit register port and one peripheral clock
package toc_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_MODE    = 8'h89;
	localparam logic [7:0] ADDR_LOW     = 8'h8B;
	localparam logic [7:0] ADDR_HIGH    = 8'h8D;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'hA0;
	// Control register bits
	localparam int CTL_T1_OVF  = 7;
	localparam int CTL_T1_RUN  = 6;
	localparam int CTL_T0_OVF  = 5;
	localparam int CTL_T0_RUN  = 4;
	localparam int CTL_X1_FLAG = 3;
	localparam int CTL_X1_TYPE = 2;
	localparam int CTL_X0_FLAG = 1;
	localparam int CTL_X0_TYPE = 0;
	// Mode register fields (upper nibble)
	localparam int MOD_GATE    = 7;
	localparam int MOD_SOURCE  = 6;
	localparam int MOD_MODE_HI = 5;
	localparam int MOD_MODE_LO = 4;
	// Interrupt enable bits
	localparam int IEN_GLOBAL = 7;
	localparam int IEN_T1     = 3;
	localparam int IEN_T0     = 1;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	// Peripheral clocks per peripheral cycle
	localparam int PER_CLOCKS = 6;
	// Prescaler top in mode 0
	localparam logic [4:0] PRESC_TOP = 5'h1F;
	// Mode encoding, in order of the field code
	typedef enum logic [1:0] {
		TOC_MODE_13BIT,
		TOC_MODE_16BIT,
		TOC_MODE_RELOAD,
		TOC_MODE_HOLD
	} toc_mode_type;
endpackage

//--- hw/toc_timer_one.sv
// Timer one counter with the shared timer control register
// Assumes all pins synchronous to mclk; acks are one-cycle pulses
//
// The address-and-strobe port was chosen for this implementation.
module toc_timer_one
	import toc_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rstn,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	// External pins, active low irq pins
	input  wire logic       ext_irq_one_pin_n,
	input  wire logic       ext_irq_zero_pin_n,
	input  wire logic       timer_one_count_pin,
	// Other timer side
	input  wire logic       timer_zero_ovf,
	input  wire logic       timer_zero_split,
	input  wire logic       timer_zero_high_ovf,
	output logic            timer_zero_run,
	// Vectoring acknowledges
	input  wire logic       ack_timer_one,
	input  wire logic       ack_timer_zero,
	input  wire logic       ack_ext_one,
	input  wire logic       ack_ext_zero,
	// Requests and baud clock
	output logic            irq_timer_one,
	output logic            irq_timer_zero,
	output logic            irq_ext_one,
	output logic            irq_ext_zero,
	output logic            baud_tick
);
	logic [7:0]   control;       // Shared control bits
	logic [3:0]   mode_nib;      // Upper nibble of mode reg
	logic [7:0]   timer_one_low_byte;
	logic [7:0]   timer_one_high_byte;
	logic [7:0]   irq_en;        // Enable register
	logic [2:0]   per_cnt;       // Six-clock divider
	logic         per_en;        // Peripheral cycle strobe
	logic         cnt_sample;    // Count pin sample
	logic         x0_sample;     // Irq-zero pin sample
	logic         x1_sample;     // Irq-one pin sample
	logic         cnt_fall;      // High then low seen
	logic         x0_fall;
	logic         x1_fall;
	logic         run;           // Counting allowed
	logic         tick;          // One count this cycle
	logic         ovf;           // Rollover this cycle
	logic         set_t1;        // Hardware sets flag
	toc_mode_type mode;

	// Decoded writes
	logic wr_ctl;
	logic wr_mod;
	logic wr_low;
	logic wr_high;
	assign wr_ctl  = wr && addr == ADDR_CONTROL;
	assign wr_mod  = wr && addr == ADDR_MODE;
	assign wr_low  = wr && addr == ADDR_LOW;
	assign wr_high = wr && addr == ADDR_HIGH;

	// Mode field in the upper nibble
	assign mode = toc_mode_type'(mode_nib[MOD_MODE_HI-4:MOD_MODE_LO-4]);

	// Peripheral cycle divider
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			per_cnt <= 3'h0;
			per_en  <= 1'b0;
		end else if (per_cnt == 3'(PER_CLOCKS - 1)) begin
			per_cnt <= 3'h0;
			per_en  <= 1'b1;
		end else begin
			per_cnt <= per_cnt + 3'h1;
			per_en  <= 1'b0;
		end
	end

	// Pin samples, once per peripheral cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_sample <= 1'b0;
			x0_sample  <= 1'b1;
			x1_sample  <= 1'b1;
		end else if (per_en) begin
			cnt_sample <= timer_one_count_pin;
			x0_sample  <= ext_irq_zero_pin_n;
			x1_sample  <= ext_irq_one_pin_n;
		end
	end

	// Falling edges between two samples
	assign cnt_fall = per_en && cnt_sample && !timer_one_count_pin;
	assign x0_fall  = per_en && x0_sample && !ext_irq_zero_pin_n;
	assign x1_fall  = per_en && x1_sample && !ext_irq_one_pin_n;

	// Run condition; split other timer owns the run bit
	always_comb begin
		if (timer_zero_split)
			run = 1'b1;
		else
			run = control[CTL_T1_RUN];
		if (mode_nib[MOD_GATE-4] && ext_irq_one_pin_n == 1'b0)
			run = 1'b0;
	end

	// Counted input: peripheral cycle or pin edge
	assign tick = run && mode != TOC_MODE_HOLD &&
		(mode_nib[MOD_SOURCE-4] ? cnt_fall : per_en);

	// Rollover detect per mode
	always_comb begin
		case (mode)
			TOC_MODE_13BIT:  ovf = tick && timer_one_high_byte == 8'hFF &&
				timer_one_low_byte[4:0] == PRESC_TOP;
			TOC_MODE_16BIT:  ovf = tick && timer_one_high_byte == 8'hFF &&
				timer_one_low_byte == 8'hFF;
			TOC_MODE_RELOAD: ovf = tick && timer_one_low_byte == 8'hFF;
			default:         ovf = 1'b0;
		endcase
	end

	// Low byte: writes win over counting
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			timer_one_low_byte <= RST_BYTE;
		end else if (wr_low) begin
			timer_one_low_byte <= wdata;
		end else if (tick) begin
			case (mode)
				TOC_MODE_13BIT:
					// Upper three bits left alone
					timer_one_low_byte[4:0] <= timer_one_low_byte[4:0] + 5'h01;
				TOC_MODE_RELOAD:
					if (timer_one_low_byte == 8'hFF)
						timer_one_low_byte <= timer_one_high_byte;
					else
						timer_one_low_byte <= timer_one_low_byte + 8'h01;
				default:
					timer_one_low_byte <= timer_one_low_byte + 8'h01;
			endcase
		end
	end

	// High byte: carries from the low side
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			timer_one_high_byte <= RST_BYTE;
		end else if (wr_high) begin
			timer_one_high_byte <= wdata;
		end else if (tick) begin
			case (mode)
				TOC_MODE_13BIT:
					if (timer_one_low_byte[4:0] == PRESC_TOP)
						timer_one_high_byte <= timer_one_high_byte + 8'h01;
				TOC_MODE_16BIT:
					if (timer_one_low_byte == 8'hFF)
						timer_one_high_byte <= timer_one_high_byte + 8'h01;
				default:
					// Reload and hold keep high byte
					timer_one_high_byte <= timer_one_high_byte;
			endcase
		end
	end

	// Mode and enable registers; mode changes with the
	// timer stopped are the caller's duty
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mode_nib <= 4'h0;
			irq_en   <= RST_BYTE;
		end else begin
			if (wr_mod)
				mode_nib <= wdata[7:4];
			if (wr && addr == ADDR_IRQ_EN)
				irq_en <= wdata;
		end
	end

	// Own flag set: in split mode the other timer drives it
	assign set_t1 = timer_zero_split ? timer_zero_high_ovf : ovf;

	// Control register; hardware sets win over any clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			control <= RST_BYTE;
		end else begin
			if (wr_ctl)
				control <= wdata;
			// This timer's overflow flag
			if (set_t1)
				control[CTL_T1_OVF] <= 1'b1;
			else if (ack_timer_one)
				control[CTL_T1_OVF] <= 1'b0;
			// Other timer's overflow flag
			if (timer_zero_ovf)
				control[CTL_T0_OVF] <= 1'b1;
			else if (ack_timer_zero)
				control[CTL_T0_OVF] <= 1'b0;
			// Irq-one flag: level follows pin, edge latches
			if (!control[CTL_X1_TYPE])
				control[CTL_X1_FLAG] <= !ext_irq_one_pin_n;
			else if (x1_fall)
				control[CTL_X1_FLAG] <= 1'b1;
			else if (ack_ext_one)
				control[CTL_X1_FLAG] <= 1'b0;
			// Irq-zero flag, same scheme
			if (!control[CTL_X0_TYPE])
				control[CTL_X0_FLAG] <= !ext_irq_zero_pin_n;
			else if (x0_fall)
				control[CTL_X0_FLAG] <= 1'b1;
			else if (ack_ext_zero)
				control[CTL_X0_FLAG] <= 1'b0;
		end
	end

	// Requests and side outputs, all registered
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_timer_one  <= 1'b0;
			irq_timer_zero <= 1'b0;
			irq_ext_one    <= 1'b0;
			irq_ext_zero   <= 1'b0;
			baud_tick      <= 1'b0;
			timer_zero_run <= 1'b0;
		end else begin
			// Split mode: no interrupt from own overflow
			irq_timer_one  <= control[CTL_T1_OVF] && irq_en[IEN_T1] &&
				irq_en[IEN_GLOBAL];
			irq_timer_zero <= control[CTL_T0_OVF] && irq_en[IEN_T0] &&
				irq_en[IEN_GLOBAL];
			irq_ext_one    <= control[CTL_X1_FLAG];
			irq_ext_zero   <= control[CTL_X0_FLAG];
			baud_tick      <= ovf;
			timer_zero_run <= control[CTL_T0_RUN];
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdata <= RST_BYTE;
		end else if (rd) begin
			case (addr)
				ADDR_CONTROL: rdata <= control;
				ADDR_MODE:    rdata <= {mode_nib, 4'h0};
				ADDR_LOW:     rdata <= timer_one_low_byte;
				ADDR_HIGH:    rdata <= timer_one_high_byte;
				ADDR_IRQ_EN:  rdata <= irq_en;
				default:      rdata <= RST_BYTE; // Unmapped reads zero
			endcase
		end else begin
			rdata <= RST_BYTE;
		end
	end

	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_prescale;
		tick && mode == TOC_MODE_13BIT && timer_one_low_byte[4:0] == PRESC_TOP && !wr_high
		|=> timer_one_high_byte == $past(timer_one_high_byte) + 8'h01;
	endproperty
	a_prescale: assert property (p_prescale) else $error("mode 0 carry lost");

	property p_cascade;
		tick && mode == TOC_MODE_16BIT && timer_one_low_byte == 8'hFF && !wr_high && !wr_low
		|=> timer_one_high_byte == $past(timer_one_high_byte) + 8'h01 &&
			timer_one_low_byte == 8'h00;
	endproperty
	a_cascade: assert property (p_cascade) else $error("mode 1 carry lost");

	property p_reload;
		tick && mode == TOC_MODE_RELOAD && timer_one_low_byte == 8'hFF && !wr_low && !wr_high
		|=> timer_one_low_byte == $past(timer_one_high_byte) && $stable(timer_one_high_byte);
	endproperty
	a_reload: assert property (p_reload) else $error("mode 2 reload wrong");

	property p_hold;
		mode == TOC_MODE_HOLD && !wr_low && !wr_high
		|=> $stable(timer_one_low_byte) && $stable(timer_one_high_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("mode 3 count moved");

	property p_gate;
		mode_nib[MOD_GATE-4] && !ext_irq_one_pin_n |-> !tick;
	endproperty
	a_gate: assert property (p_gate) else $error("gated timer counted");

	property p_ovf_flag;
		ovf && !timer_zero_split |=> control[CTL_T1_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

	property p_ack;
		ack_timer_one && !set_t1 |=> !control[CTL_T1_OVF];
	endproperty
	a_ack: assert property (p_ack) else $error("vector ack did not clear");

	property p_irq;
		irq_timer_one |-> $past(control[CTL_T1_OVF] && irq_en[IEN_T1] && irq_en[IEN_GLOBAL]);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without enables");

	property p_period;
		per_en |=> !per_en [*5] ##1 per_en;
	endproperty
	a_period: assert property (p_period) else $error("peripheral cycle not six clocks");

	property p_edge0;
		control[CTL_X0_TYPE] && x0_fall |=> control[CTL_X0_FLAG];
	endproperty
	a_edge0: assert property (p_edge0) else $error("irq-zero edge lost");

	property p_baud;
		ovf |=> baud_tick;
	endproperty
	a_baud: assert property (p_baud) else $error("baud pulse missing after rollover");

	property p_run;
		!timer_zero_split && !control[CTL_T1_RUN] |-> !tick;
	endproperty
	a_run: assert property (p_run) else $error("stopped timer counted");

	property p_t0_flag;
		timer_zero_ovf |=> control[CTL_T0_OVF];
	endproperty
	a_t0_flag: assert property (p_t0_flag) else $error("other timer flag not set");

	property p_edge1;
		control[CTL_X1_TYPE] && x1_fall |=> control[CTL_X1_FLAG];
	endproperty
	a_edge1: assert property (p_edge1) else $error("irq-one edge lost");

	property p_level1;
		!control[CTL_X1_TYPE] |=> control[CTL_X1_FLAG] == !$past(ext_irq_one_pin_n);
	endproperty
	a_level1: assert property (p_level1) else $error("irq-one level flag wrong");

	property p_level0;
		!control[CTL_X0_TYPE] |=> control[CTL_X0_FLAG] == !$past(ext_irq_zero_pin_n);
	endproperty
	a_level0: assert property (p_level0) else $error("irq-zero level flag wrong");

	property p_upper;
		tick && mode == TOC_MODE_13BIT && !wr_low |=> $stable(timer_one_low_byte[7:5]);
	endproperty
	a_upper: assert property (p_upper) else $error("mode 0 upper low bits moved");
endmodule

//--- test/toc_pin_model.sv
// Model of the count input and the two irq pins outside the block
// Assumes the bench calls its tasks; levels change just after mclk rises
module toc_pin_model (
	// Clock
	input  wire logic mclk,
	// Driven pins
	output logic      count_pin,
	output logic      irq_one_n,
	output logic      irq_zero_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle levels: irq pins high, count pin low
	initial begin
		count_pin = 1'b0;
		irq_one_n = 1'b1;
		irq_zero_n = 1'b1;
	end
	// Each level held 8 clocks so a 6-clock sampler always sees it
	task automatic falls(input int n);
		repeat (n) begin
			@(posedge mclk);
			count_pin <= 1'b1;
			repeat (8) @(posedge mclk);
			count_pin <= 1'b0;
			repeat (8) @(posedge mclk);
		end
	endtask
	// Irq-one pin doubles as the gate input
	task automatic set_pins(input logic one_n, input logic zero_n);
		@(posedge mclk);
		irq_one_n <= one_n;
		irq_zero_n <= zero_n;
	endtask
endmodule

//--- test/toc_timer_one_tb.sv
// Self-checking bench for the timer one block
// Assumes the pin model drives the count and irq pins
module toc_timer_one_tb;
	import toc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// Bus, side-band and observed signals
	logic        mclk, rstn, wr, rd, split0, run0, baud, cpin, x1_n, x0_n;
	logic [7:0]  addr, wdata, rdata, v;
	logic [5:0]  ev;
	logic [3:0]  irq;
	logic [31:0] seed;
	int          num_errors, checks_done;
	// Every mapped address plus one hole
	logic [7:0]  amap [6] = '{ADDR_CONTROL, ADDR_MODE, ADDR_LOW, ADDR_HIGH, ADDR_IRQ_EN, 8'h8A};
	toc_timer_one dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ext_irq_one_pin_n(x1_n), .ext_irq_zero_pin_n(x0_n), .timer_one_count_pin(cpin),
		.timer_zero_ovf(ev[4]), .timer_zero_split(split0), .timer_zero_high_ovf(ev[5]),
		.timer_zero_run(run0), .ack_timer_one(ev[3]), .ack_timer_zero(ev[2]), .ack_ext_one(ev[1]),
		.ack_ext_zero(ev[0]), .irq_timer_one(irq[3]), .irq_timer_zero(irq[2]), .irq_ext_one(irq[1]),
		.irq_ext_zero(irq[0]), .baud_tick(baud));
	toc_pin_model pins (.mclk(mclk), .count_pin(cpin), .irq_one_n(x1_n), .irq_zero_n(x0_n));
	// 100 ns clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Verdict and end of run
	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One comparison
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// Bus cycles; read data sampled in the single cycle it stands
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		{rd, addr} <= {1'b1, a};
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One-cycle pulse on an ack or other-timer event line
	task automatic pulse(input int i);
		@(posedge mclk);
		ev[i] <= 1'b1;
		@(posedge mclk);
		ev[i] <= 1'b0;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected {high, low} just after a rollover from all ones
	function automatic logic [15:0] after_roll(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
		case (m)
			2'h0: return {8'h00, lo & 8'hE0};
			2'h1: return 16'h0000;
			default: return {hi, hi};
		endcase
	endfunction
	// Bounded wait for the baud pulse
	task automatic wait_baud();
		int n;
		n = 0;
		while (baud !== 1'b1) begin
			@(posedge mclk);
			#1 n++;
			if (n > 50) begin
				num_errors++;
				$display("BAD %0t baud pulse never came", $time);
				finish_test();
			end
		end
	endtask
	// Run into a rollover, halt with mode 3, then check count, flag and irq
	task automatic run_roll(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] ien, input logic [7:0] ectl, input logic eirq);
		logic [15:0] e;
		e = after_roll(m, lo, hi);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_MODE, 8'h30);
		wr_reg(ADDR_IRQ_EN, ien);
		wr_reg(ADDR_LOW, lo);
		wr_reg(ADDR_HIGH, hi);
		// Split: run bit is not ours, leaving mode 3 is the start
		if (!split0)
			wr_reg(ADDR_MODE, {2'h0, m, 4'h0});
		wr_reg(ADDR_CONTROL, 8'h40);
		if (split0)
			wr_reg(ADDR_MODE, {2'h0, m, 4'h0});
		wait_baud();
		wr_reg(ADDR_MODE, 8'h30);
		rd_reg(ADDR_CONTROL, v);
		check(v, ectl);
		check({7'h0, irq[3]}, {7'h0, eirq});
		pulse(3);
		tick(2);
		rd_reg(ADDR_CONTROL, v);
		check(v, 8'h40);
		check({7'h0, irq[3]}, 8'h00);
		tick(30);
		rd_reg(ADDR_LOW, v);
		check(v, e[7:0]);
		rd_reg(ADDR_HIGH, v);
		check(v, e[15:8]);
	endtask
	// Count pin falls with the gate shut, then open
	task automatic count_edges(input logic [7:0] m, input int shut, input int open, input logic [7:0] e);
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_MODE, m);
		wr_reg(ADDR_LOW, 8'h00);
		pins.set_pins(1'b0, 1'b1);
		wr_reg(ADDR_CONTROL, 8'h40);
		pins.falls(shut);
		pins.set_pins(1'b1, 1'b1);
		pins.falls(open);
		tick(10);
		wr_reg(ADDR_CONTROL, 8'h00);
		rd_reg(ADDR_LOW, v);
		check(v, e);
	endtask
	// Main sequence
	initial begin
		{rstn, wr, rd, split0, addr, wdata, ev} = '0;
		num_errors = 0;
		checks_done = 0;
		seed = 32'h46BE;
		tick(6);
		rstn <= 1'b1;
		foreach (amap[i]) begin
			rd_reg(amap[i], v);
			check(v, RST_BYTE);
		end
		// Random register contents, mode lower nibble not stored
		repeat (4) begin
			seed = lfsr(seed);
			wr_reg(ADDR_LOW, seed[7:0]);
			wr_reg(ADDR_HIGH, seed[15:8]);
			wr_reg(ADDR_MODE, seed[23:16]);
			wr_reg(8'h8A, seed[31:24]);
			rd_reg(ADDR_LOW, v);
			check(v, seed[7:0]);
			rd_reg(ADDR_HIGH, v);
			check(v, seed[15:8]);
			rd_reg(ADDR_MODE, v);
			check(v, {seed[23:20], 4'h0});
		end
		run_roll(2'h0, 8'hFF, 8'hFF, 8'h88, 8'hC0, 1'b1);
		run_roll(2'h1, 8'hFF, 8'hFF, 8'h08, 8'hC0, 1'b0);
		run_roll(2'h2, 8'hFF, 8'h5A, 8'h80, 8'hC0, 1'b0);
		// Rate: one step per six clocks over about 122 clocks
		wr_reg(ADDR_CONTROL, 8'h00);
		wr_reg(ADDR_LOW, 8'h00);
		wr_reg(ADDR_MODE, 8'h10);
		wr_reg(ADDR_CONTROL, 8'h40);
		tick(120);
		wr_reg(ADDR_MODE, 8'h30);
		rd_reg(ADDR_LOW, v);
		check({7'h0, v >= 8'h14 && v <= 8'h15}, 8'h01);
		count_edges(8'h50, 3, 2, 8'h05);
		count_edges(8'hD0, 3, 2, 8'h02);
		seed = lfsr(seed);
		count_edges(8'hD0, 0, seed[2:0], {5'h0, seed[2:0]});
		// External irq flags, edge then level type
		for (int i = 0; i < 2; i++) begin
			wr_reg(ADDR_CONTROL, 8'h05);
			pins.set_pins(i == 0, i == 1);
			tick(14);
			pins.set_pins(1'b1, 1'b1);
			tick(2);
			rd_reg(ADDR_CONTROL, v);
			check(v, 8'h05 | (8'h02 << (2 * i)));
			check({7'h0, irq[i]}, 8'h01);
			pulse(i);
			tick(2);
			rd_reg(ADDR_CONTROL, v);
			check(v, 8'h05);
			wr_reg(ADDR_CONTROL, 8'h00);
			pins.set_pins(i == 0, i == 1);
			pulse(i);
			tick(2);
			rd_reg(ADDR_CONTROL, v);
			check(v, 8'h02 << (2 * i));
			pins.set_pins(1'b1, 1'b1);
			tick(3);
			rd_reg(ADDR_CONTROL, v);
			check(v, 8'h00);
		end
		// Other timer: run bit, overflow flag and its irq
		wr_reg(ADDR_IRQ_EN, 8'h82);
		wr_reg(ADDR_CONTROL, 8'h10);
		tick(2);
		#1 check({7'h0, run0}, 8'h01);
		pulse(4);
		tick(2);
		rd_reg(ADDR_CONTROL, v);
		check(v, 8'h30);
		check({7'h0, irq[2]}, 8'h01);
		pulse(2);
		tick(2);
		rd_reg(ADDR_CONTROL, v);
		check(v, 8'h10);
		// Split: flag 7 belongs to the other timer's high half
		@(posedge mclk);
		split0 <= 1'b1;
		pulse(5);
		tick(2);
		rd_reg(ADDR_CONTROL, v);
		check(v, 8'h90);
		pulse(3);
		run_roll(2'h1, 8'hFF, 8'hFF, 8'h88, 8'h40, 1'b0);
		finish_test();
	end
endmodule
